// File: verilog/pkd_channel.sv
// One pulse generator channel: counter, output actions, kill, dead time.
// Assumes a classic Wishbone master and trigger inputs synchronous to mclk.
`timescale 1ns/1ps
// Function
// - Kill blocks both outputs at once.
// - Stop-on-kill clear: counter keeps running.
// - Stop-on-kill set: counter halts too.
// - Async kill blocks only while the selected kill trigger event is present.
// - Sync kill blocks until next terminal count.
// - No start after sync kill before count.
// - Kill stop event disables both outputs.
// - Pulse mode prescale from shared setting.
// - Period and compare with shadow copies.
// - Direction field selects pulse alignment.
// - Output actions on match, overflow, underflow.
// - Counter waits for a start event.
// - Dead band up to 255 clocks.
// - Rising edge: both low, then true output.
// - Falling edge: both low, then complement.
// - Zero dead band follows the line.
// - Dead band covering pulse removes it.
// - Dead-time mode has no prescaling.
// - Dead-time mode keeps all pulse features but prescaling.
// - Switch remembered, swap at terminal count.
// - Center mode clears at count, toggles match.
module pkd_channel
    import pkd_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire pkd_pkg::pkd_wbreq_s wbReq,
    input wire logic [pkd_pkg::NTRIG-1:0] trigIn,
    output logic [31:0] wbDatO,
    output logic wbAck,
    output logic pwmOut,
    output logic pwmOutN
);
    import pkd_pkg::*;

    // ==========================================================
    // Register file.
    logic wbAck_ff;
    logic [31:0] wbDat_ff;
    logic ctrlEn_ff;
    logic [31:0] cfg_ff;
    logic [15:0] per_ff;
    logic [15:0] perSh_ff;
    logic [15:0] cmp_ff;
    logic [15:0] cmpSh_ff;
    logic [3:0] trSel_ff;
    logic [7:0] trEdge_ff;
    logic [5:0] outAct_ff;
    logic [31:0] rdVal;
    logic [31:0] wrData;
    logic wbHit;
    logic wrEn;
    logic [3:0] cmdPulse;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
                r[b*8 +: 8] = n[b*8 +: 8];
        end
        return r;
    endfunction : merge

    function automatic logic act(input logic v, input logic [1:0] code);
        case (code)
            ACT_SET: return 1'b1;
            ACT_CLR: return 1'b0;
            ACT_INV: return ~v;
            default: return v;
        endcase
    endfunction : act

    assign wbHit = wbReq.cyc & wbReq.stb & ~wbAck_ff;
    // A write lands at the edge where the master samples ack, while its request still stands.
    assign wrEn = wbReq.cyc & wbReq.stb & wbReq.we & wbAck_ff;
    assign wrData = merge(rdVal, wbReq.dat, wbReq.sel);
    assign cmdPulse = (wrEn && wbReq.adr == ADR_CMD) ? wrData[3:0] : 4'h0;

    // ==========================================================
    // Channel state declarations.
    pkd_state_e state_ff;
    logic [15:0] cnt_ff;
    logic dir_ff;
    logic [7:0] psc_ff;
    logic line_ff;
    logic prevLine_ff;
    logic [7:0] dtCnt_ff;
    logic dtHi_ff;
    logic dtLo_ff;
    logic killLatch_ff;
    logic swapPend_ff;
    logic [NTRIG-1:0] trigPrev_ff;
    logic [NTRIG-1:0] trigEvt;
    logic [7:0] gen;
    logic [1:0] ud;
    logic modeDt;
    logic running;
    logic tick;
    logic killNow;
    logic startEv;
    logic reloadEv;
    logic stopEv;
    logic switchEv;
    logic tcEv;
    logic ccEv;
    logic ovEv;
    logic unEv;
    logic tcCnt;
    logic blocked;
    logic [15:0] nxt_cnt;
    logic nxt_dir;
    logic nxt_line;

    assign gen = cfg_ff[CFG_GEN +: 8];
    assign ud = cfg_ff[CFG_UD +: 2];
    assign modeDt = cfg_ff[CFG_MODE +: 3] == MODE_DT;
    assign running = state_ff == ST_RUN;

    always_comb
    begin
        rdVal = 32'h0000_0000;
        case (wbReq.adr)
            ADR_CTRL: rdVal[0] = ctrlEn_ff;
            ADR_CFG: rdVal = cfg_ff;
            ADR_STAT: rdVal = {dtCnt_ff, 6'h00, dir_ff, running, cnt_ff};
            ADR_PER: rdVal[15:0] = per_ff;
            ADR_PERSH: rdVal[15:0] = perSh_ff;
            ADR_CMP: rdVal[15:0] = cmp_ff;
            ADR_CMPSH: rdVal[15:0] = cmpSh_ff;
            ADR_TRSEL: rdVal[3:0] = trSel_ff;
            ADR_TREDGE: rdVal[7:0] = trEdge_ff;
            ADR_OUTACT: rdVal[5:0] = outAct_ff;
            default: rdVal = 32'h0000_0000;
        endcase
    end

    // Every access, mapped or not, is answered one cycle after it is seen.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wbAck_ff <= 1'b0;
            wbDat_ff <= 32'h0000_0000;
        end
        else
        begin
            wbAck_ff <= wbHit;
            if (wbHit && !wbReq.we)
                wbDat_ff <= rdVal;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrlEn_ff <= 1'b0;
            cfg_ff <= CFG_RST;
            perSh_ff <= CNT_ZERO;
            cmpSh_ff <= CNT_ZERO;
            trSel_ff <= 4'h0;
            trEdge_ff <= TREDGE_RST;
            outAct_ff <= OUTACT_RST;
        end
        else
        begin
            // shadows take old active values.
            // The shadows take the old active values, so two switches restore them.
            if (tcEv && swapPend_ff)
            begin
                if (cfg_ff[CFG_SWPER])
                    perSh_ff <= per_ff;
                if (cfg_ff[CFG_SWCMP])
                    cmpSh_ff <= cmp_ff;
            end
            // A software write in the same cycle wins over the swap.
            if (wrEn)
            begin
                case (wbReq.adr)
                    ADR_CTRL: ctrlEn_ff <= wrData[0];
                    ADR_CFG: cfg_ff <= wrData;
                    ADR_PERSH: perSh_ff <= wrData[15:0];
                    ADR_CMPSH: cmpSh_ff <= wrData[15:0];
                    ADR_TRSEL: trSel_ff <= wrData[3:0];
                    ADR_TREDGE: trEdge_ff <= wrData[7:0];
                    ADR_OUTACT: outAct_ff <= wrData[5:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            per_ff <= CNT_ZERO;
            cmp_ff <= CNT_ZERO;
        end
        else if (wrEn && wbReq.adr == ADR_PER)
            per_ff <= wrData[15:0];
        else if (wrEn && wbReq.adr == ADR_CMP)
            cmp_ff <= wrData[15:0];
        else if (tcEv && swapPend_ff)
        begin
            if (cfg_ff[CFG_SWPER])
                per_ff <= perSh_ff;
            if (cfg_ff[CFG_SWCMP])
                cmp_ff <= cmpSh_ff;
        end
    end

    // ==========================================================
    // Trigger detection, one edge selector per input.
    genvar gi;
    generate
        for (gi = 0; gi < NTRIG; gi++)
        begin : g_trig
            logic [1:0] es;
            logic rise;
            logic fall;
            assign es = trEdge_ff[2*gi +: 2];
            assign rise = trigIn[gi] & ~trigPrev_ff[gi];
            assign fall = ~trigIn[gi] & trigPrev_ff[gi];
            assign trigEvt[gi] = trSel_ff[gi] & (es == EDG_RISE ? rise :
                                 es == EDG_FALL ? fall :
                                 es == EDG_BOTH ? (rise | fall) : trigIn[gi]);
        end
    endgenerate

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            trigPrev_ff <= '0;
        else
            trigPrev_ff <= trigIn;
    end

    assign killNow = cfg_ff[CFG_SYNCK] ? (killLatch_ff | trigEvt[TRG_KILL])
                                       : trigEvt[TRG_KILL];
    assign startEv = (cmdPulse[CMD_START] | trigEvt[TRG_START]) & ~killLatch_ff;
    assign reloadEv = ctrlEn_ff & (cmdPulse[CMD_RELOAD] | trigEvt[TRG_RELOAD]);
    assign stopEv = cmdPulse[CMD_STOP] | (killNow & cfg_ff[CFG_STOPK] & running);
    // A pass-through switch input is a level, so it cannot request a swap.
    assign switchEv = cmdPulse[CMD_SWITCH] |
                      (trigEvt[TRG_SWITCH] & trEdge_ff[2*TRG_SWITCH +: 2] != EDG_PASS);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            killLatch_ff <= 1'b0;
        else if (cfg_ff[CFG_SYNCK] && trigEvt[TRG_KILL])
            killLatch_ff <= 1'b1;
        else if (tcEv || !cfg_ff[CFG_SYNCK])
            killLatch_ff <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            swapPend_ff <= 1'b0;
        else if (switchEv)
            swapPend_ff <= 1'b1;
        else if (tcEv)
            swapPend_ff <= 1'b0;
    end

    // ==========================================================
    // Run control and counter.
    // disabled stays idle; kill keeps running unless stop-on-kill is set.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= ST_IDLE;
        else
        begin
            case (state_ff)
                ST_IDLE:
                    if (ctrlEn_ff && (reloadEv || (startEv && !stopEv)))
                        state_ff <= ST_RUN;
                ST_RUN:
                    if (!ctrlEn_ff || (stopEv && !reloadEv))
                        state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    assign tick = running & (modeDt | psc_ff == gen);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            psc_ff <= 8'h00;
        else if (!running || tick)
            psc_ff <= 8'h00;
        else
            psc_ff <= psc_ff + DT_ONE;
    end

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        ovEv = 1'b0;
        unEv = 1'b0;
        tcCnt = 1'b0;
        case (ud)
            UD_UP:
                if (cnt_ff == per_ff)
                begin
                    nxt_cnt = CNT_ZERO;
                    ovEv = 1'b1;
                    tcCnt = 1'b1;
                end
                else
                    nxt_cnt = cnt_ff + CNT_ONE;
            UD_DN:
                if (cnt_ff == CNT_ZERO)
                begin
                    nxt_cnt = per_ff;
                    unEv = 1'b1;
                    tcCnt = 1'b1;
                end
                else
                    nxt_cnt = cnt_ff - CNT_ONE;
            default:
                if (!dir_ff && cnt_ff == per_ff)
                begin
                    nxt_dir = 1'b1;
                    nxt_cnt = cnt_ff - CNT_ONE;
                    ovEv = 1'b1;
                    tcCnt = ud != UD_CTR;
                end
                else if (dir_ff && cnt_ff == CNT_ZERO)
                begin
                    nxt_dir = 1'b0;
                    nxt_cnt = cnt_ff + CNT_ONE;
                    unEv = 1'b1;
                    tcCnt = 1'b1;
                end
                else
                    nxt_cnt = dir_ff ? cnt_ff - CNT_ONE : cnt_ff + CNT_ONE;
        endcase
    end

    // A reload reinitialises the counter and counts as a terminal count.
    assign tcEv = (tick & tcCnt) | reloadEv;
    assign ccEv = tick & cnt_ff == cmp_ff;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff <= CNT_ZERO;
            dir_ff <= 1'b0;
        end
        else if (!ctrlEn_ff)
        begin
            cnt_ff <= CNT_ZERO;
            dir_ff <= 1'b0;
        end
        else if (reloadEv)
        begin
            cnt_ff <= ud == UD_DN ? per_ff : CNT_ZERO;
            dir_ff <= 1'b0;
        end
        else if (tick)
        begin
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
        end
    end

    // ==========================================================
    // Pulse line and output actions.
    always_comb
    begin
        nxt_line = line_ff;
        // center clears at count, toggles match.
        if (ud == UD_CTR)
        begin
            if (tick && tcCnt)
                nxt_line = 1'b0;
            else if (ccEv)
                nxt_line = ~line_ff;
        end
        else if (tick)
        begin
            if (ovEv)
                nxt_line = act(nxt_line, outAct_ff[OA_OV +: 2]);
            if (unEv)
                nxt_line = act(nxt_line, outAct_ff[OA_UN +: 2]);
            if (ccEv)
                nxt_line = act(nxt_line, outAct_ff[OA_CC +: 2]);
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            line_ff <= 1'b0;
        else if (!ctrlEn_ff)
            line_ff <= 1'b0;
        else
            line_ff <= nxt_line;
    end

    // ==========================================================
    // Dead-time stage.
    // edges restart band.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prevLine_ff <= 1'b0;
            dtCnt_ff <= 8'h00;
            dtHi_ff <= 1'b0;
            dtLo_ff <= 1'b0;
        end
        else
        begin
            prevLine_ff <= line_ff;
            if (line_ff != prevLine_ff)
            begin
                // zero band passes the line straight.
                dtHi_ff <= gen == 8'h00 ? line_ff : 1'b0;
                dtLo_ff <= gen == 8'h00 ? ~line_ff : 1'b0;
                dtCnt_ff <= gen;
            end
            else if (dtCnt_ff != 8'h00)
            begin
                dtCnt_ff <= dtCnt_ff - DT_ONE;
                if (dtCnt_ff == DT_ONE)
                begin
                    dtHi_ff <= line_ff;
                    dtLo_ff <= ~line_ff;
                end
            end
        end
    end

    // ==========================================================
    // Output pins.
    // kill or disable forces low.
    assign blocked = killNow | ~ctrlEn_ff;

    // dead-time mode shares all counter features but the prescaler.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pwmOut <= 1'b0;
            pwmOutN <= 1'b0;
        end
        else if (blocked)
        begin
            pwmOut <= 1'b0;
            pwmOutN <= 1'b0;
        end
        else
        begin
            pwmOut <= modeDt ? dtHi_ff : line_ff;
            pwmOutN <= modeDt ? dtLo_ff : ~line_ff;
        end
    end

    assign wbAck = wbAck_ff;
    assign wbDatO = wbDat_ff;

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_dtEdge;
        modeDt && gen != 8'h00 && line_ff != prevLine_ff;
    endsequence

    a_kill_blocks: assert property (killNow |=> !pwmOut && !pwmOutN)
        else $error("kill did not block outputs");
    a_kill_keeps: assert property (running && killNow && !cfg_ff[CFG_STOPK] && ctrlEn_ff
        && !cmdPulse[CMD_STOP] |=> running)
        else $error("counter stopped on kill");
    a_kill_halts: assert property (running && killNow && cfg_ff[CFG_STOPK]
        && !reloadEv |=> !running)
        else $error("counter ran on kill");
    a_sync_hold: assert property (cfg_ff[CFG_SYNCK] && killLatch_ff && !tcEv
        |=> killLatch_ff && !pwmOut)
        else $error("sync kill released early");
    a_no_restart: assert property (!running && killLatch_ff && !reloadEv
        |=> !running)
        else $error("restart before count");
    a_swap_tc: assert property (tcEv && swapPend_ff && cfg_ff[CFG_SWCMP] && !wrEn
        |=> cmp_ff == $past(cmpSh_ff) && swapPend_ff == $past(switchEv))
        else $error("compare not swapped");
    a_dead_band: assert property (s_dtEdge ##0 !blocked |=> !dtHi_ff && !dtLo_ff)
        else $error("dead band not low");
    a_dt_zero: assert property (modeDt && gen == 8'h00 && line_ff != prevLine_ff
        |=> dtHi_ff == $past(line_ff))
        else $error("zero band does not follow");
    a_center_tc: assert property (ud == UD_CTR && tick && tcCnt && ctrlEn_ff
        |=> !line_ff)
        else $error("center line not cleared");
    a_off_low: assert property (!ctrlEn_ff |=> !pwmOut && !pwmOutN && !running)
        else $error("disabled channel active");
endmodule : pkd_channel

// File: verilog/pkd_pkg.sv
// Package for the pulse generator channel with kill and dead-time stages.
// Assumes a classic Wishbone master with 32-bit data and byte selects.
package pkd_pkg;
    // ==========================================================
    // Register offsets.
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_CFG = 8'h08;
    localparam logic [7:0] ADR_STAT = 8'h0c;
    localparam logic [7:0] ADR_PER = 8'h10;
    localparam logic [7:0] ADR_PERSH = 8'h14;
    localparam logic [7:0] ADR_CMP = 8'h18;
    localparam logic [7:0] ADR_CMPSH = 8'h1c;
    localparam logic [7:0] ADR_TRSEL = 8'h20;
    localparam logic [7:0] ADR_TREDGE = 8'h24;
    localparam logic [7:0] ADR_OUTACT = 8'h28;
    // ==========================================================
    // Field positions.
    localparam int CFG_SWCMP = 0;
    localparam int CFG_SWPER = 1;
    localparam int CFG_STOPK = 2;
    localparam int CFG_SYNCK = 3;
    localparam int CFG_GEN = 8;
    localparam int CFG_UD = 16;
    localparam int CFG_MODE = 24;
    localparam int CMD_START = 0;
    localparam int CMD_RELOAD = 1;
    localparam int CMD_STOP = 2;
    localparam int CMD_SWITCH = 3;
    localparam int NTRIG = 4;
    localparam int TRG_START = 0;
    localparam int TRG_RELOAD = 1;
    localparam int TRG_KILL = 2;
    localparam int TRG_SWITCH = 3;
    localparam int OA_CC = 0;
    localparam int OA_OV = 2;
    localparam int OA_UN = 4;
    localparam int ST_RUNBIT = 16;
    localparam int ST_DIRBIT = 17;
    localparam int ST_DT = 24;
    // ==========================================================
    // Codes and reset values.
    localparam logic [2:0] MODE_PWM = 3'h4;
    localparam logic [2:0] MODE_DT = 3'h5;
    localparam logic [1:0] UD_UP = 2'h0;
    localparam logic [1:0] UD_DN = 2'h1;
    localparam logic [1:0] UD_CTR = 2'h2;
    localparam logic [1:0] EDG_RISE = 2'h0;
    localparam logic [1:0] EDG_FALL = 2'h1;
    localparam logic [1:0] EDG_BOTH = 2'h2;
    localparam logic [1:0] EDG_PASS = 2'h3;
    localparam logic [1:0] ACT_SET = 2'h0;
    localparam logic [1:0] ACT_CLR = 2'h1;
    localparam logic [1:0] ACT_INV = 2'h2;
    localparam logic [31:0] CFG_RST = 32'h0400_0000;
    localparam logic [7:0] TREDGE_RST = 8'hff;
    localparam logic [5:0] OUTACT_RST = 6'h3f;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] DT_ONE = 8'h01;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } pkd_wbreq_s;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} pkd_state_e;
endpackage : pkd_pkg

// File: tb/pkd_load.sv
// Load meter: one switch of a half bridge, timing the gate drive it sees.
// Assumes the drive is registered on the rising edge of mclk.
`timescale 1ns/1ps
module pkd_load
(
    input wire logic mclk,
    input wire logic drvIn,
    output int perCyc,
    output int onCyc,
    output int rises
);
    // ==============================
    // Pulse timing
    int age = 0;
    int onRun = 0;
    logic drvPrev = 1'b0;
    // A gate only switches once settled, so every width is a whole cycle count.
    always @(posedge mclk)
    begin
        age <= age + 1;
        onRun <= drvIn ? onRun + 1 : 0;
        drvPrev <= drvIn;
        if (drvIn && !drvPrev)
        begin
            perCyc <= age;
            age <= 1;
            onRun <= 1;
            rises <= rises + 1;
        end
        if (!drvIn && drvPrev)
            onCyc <= onRun;
    end
endmodule : pkd_load

// File: tb/pkd_channel_tb.sv
// Bench for the pulse channel: bus tasks, two load meters, queued checks.
// Assumes one-cycle bus answers and registered pulse outputs.
`timescale 1ns/1ps
module pkd_channel_tb;
    import pkd_pkg::*;
    // ==============================
    // Signals and counters
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    pkd_wbreq_s wbReq = '0;
    logic [3:0] trigIn = 4'h0;
    logic [31:0] wbDatO;
    logic wbAck;
    logic pwmOut;
    logic pwmOutN;
    logic pwTake = 1'b0;
    logic [31:0] msk = 32'hffff_ffff;
    logic [31:0] rng = 32'h6fd37922;
    logic [31:0] v;
    logic [63:0] note;
    logic [63:0] rdQ[$];
    logic [1:0] pwQ[$];
    logic [7:0] adrs[4] = '{ADR_PER, ADR_PERSH, ADR_CMP, ADR_CMPSH};
    int hiPer, hiOn, hiRise, loOn, w0;
    int tick = 0;
    int errors = 0;
    int checks = 0;
    pkd_channel u_pkd_channel (.mclk(mclk), .rstn(rstn), .wbReq(wbReq), .trigIn(trigIn),
        .wbDatO(wbDatO), .wbAck(wbAck), .pwmOut(pwmOut), .pwmOutN(pwmOutN));
    pkd_load u_pkd_load (.mclk(mclk), .drvIn(pwmOut), .perCyc(hiPer), .onCyc(hiOn),
        .rises(hiRise));
    pkd_load u_pkd_load_n (.mclk(mclk), .drvIn(pwmOutN), .perCyc(), .onCyc(loOn),
        .rises());
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    // ==============================
    // Tasks
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // For a read the data argument is the expected word, noted before the answer.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wbReq <= '{1'b1, 1'b1, we, 4'hf, a, d};
        if (!we)
            rdQ.push_back({msk, d});
        do
            @(posedge mclk);
        while (wbAck !== 1'b1);
        wbReq <= '0;
    endtask : wb
    task automatic st(input logic e);
        msk = 32'h0001_0000;
        wb(1'b0, ADR_STAT, {15'h0, e, 16'h0});
        msk = 32'hffff_ffff;
    endtask : st
    task automatic pw(input logic [1:0] e);
        @(posedge mclk);
        pwQ.push_back(e);
        pwTake <= 1'b1;
        @(posedge mclk);
        pwTake <= 1'b0;
    endtask : pw
    task automatic run(input logic [31:0] cfg, input logic [5:0] act, input logic [15:0] per);
        wb(1'b1, ADR_CTRL, 32'h0);
        wb(1'b1, ADR_CFG, cfg);
        wb(1'b1, ADR_OUTACT, {26'h0, act});
        wb(1'b1, ADR_PER, {16'h0, per});
        wb(1'b1, ADR_CTRL, 32'h1);
        wb(1'b1, ADR_CMD, 32'h2);
        repeat (100) @(posedge mclk);
    endtask : run
    // ==============================
    // Result watcher
    always @(posedge mclk)
    begin
        tick <= tick + 1;
        if (wbAck === 1'b1 && wbReq.we === 1'b0)
        begin
            note = rdQ.pop_front();
            chk(wbDatO & note[63:32], note[31:0]);
        end
        if (pwTake)
            chk({30'h0, pwmOut, pwmOutN}, {30'h0, pwQ.pop_front()});
        if (pwmOut === 1'b1 && pwmOutN === 1'b1)
            chk(32'h3, 32'h0);
        if (tick > 20000)
        begin
            errors++;
            give_verdict();
        end
    end
    // ==============================
    // Scenarios
    initial
    begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        pw(2'h0);
        wb(1'b0, ADR_CFG, CFG_RST);
        wb(1'b0, ADR_TREDGE, {24'h0, TREDGE_RST});
        wb(1'b0, ADR_OUTACT, {26'h0, OUTACT_RST});
        wb(1'b0, ADR_CMD, 32'h0);
        wb(1'b0, 8'h3c, 32'h0);
        foreach (adrs[i])
        begin
            v = xs();
            wb(1'b1, adrs[i], v);
            wb(1'b0, adrs[i], {16'h0, v[15:0]});
        end
        wb(1'b1, ADR_PER, 32'h9);
        wb(1'b1, ADR_CMP, 32'h4);
        wb(1'b1, ADR_OUTACT, 32'h31);
        wb(1'b1, ADR_CTRL, 32'h1);
        repeat (20) @(posedge mclk);
        st(1'b0);
        wb(1'b1, ADR_CMD, 32'h1);
        repeat (40) @(posedge mclk);
        chk(hiPer, 10);
        w0 = hiOn;
        chk(w0 inside {[3:7]}, 1'b1);
        run(32'h0400_0200, 6'h31, 16'h9);
        chk(hiPer, 30);
        chk(hiOn, 3 * w0);
        run(CFG_RST, 6'h3e, 16'h9);
        chk(hiPer, 20);
        run(32'h0401_0000, 6'h1c, 16'h9);
        chk(hiPer, 10);
        run(32'h0402_0000, 6'h3f, 16'h9);
        chk(hiPer, 18);
        chk(hiOn, 10);
        run(32'h0500_0200, 6'h31, 16'h9);
        chk(hiPer, 10);
        chk(hiOn, w0 - 2);
        chk(loOn, 8 - w0);
        run(32'h0500_0000, 6'h31, 16'h9);
        chk(hiOn, w0);
        run({16'h0500, w0[7:0], 8'h0}, 6'h31, 16'h9);
        v = hiRise;
        repeat (40) @(posedge mclk);
        chk(hiRise, v);
        wb(1'b1, ADR_CFG, 32'h0500_ff00);
        wb(1'b0, ADR_CFG, 32'h0500_ff00);
        wb(1'b1, ADR_TRSEL, 32'h4);
        run(CFG_RST, 6'h31, 16'h9);
        trigIn <= 4'h4;
        repeat (3) @(posedge mclk);
        pw(2'h0);
        st(1'b1);
        trigIn <= 4'h0;
        v = hiRise;
        repeat (30) @(posedge mclk);
        chk(hiRise > v, 1'b1);
        wb(1'b1, ADR_TRSEL, 32'h6);
        wb(1'b1, ADR_TREDGE, 32'hf7);
        run(32'h0400_0004, 6'h31, 16'h9);
        trigIn <= 4'h6;
        repeat (3) @(posedge mclk);
        pw(2'h0);
        st(1'b0);
        trigIn <= 4'h0;
        repeat (3) @(posedge mclk);
        st(1'b1);
        wb(1'b1, ADR_TRSEL, 32'h4);
        wb(1'b1, ADR_TREDGE, 32'hcf);
        run(32'h0400_0008, 6'h31, 16'h31);
        // Start the kill just after a period boundary, far from the next one.
        @(posedge pwmOut);
        @(posedge mclk);
        trigIn <= 4'h4;
        @(posedge mclk);
        trigIn <= 4'h0;
        repeat (8) @(posedge mclk);
        pw(2'h0);
        v = hiRise;
        repeat (60) @(posedge mclk);
        chk(hiRise > v, 1'b1);
        run(32'h0400_000c, 6'h31, 16'h31);
        trigIn <= 4'h4;
        @(posedge mclk);
        trigIn <= 4'h0;
        repeat (4) @(posedge mclk);
        st(1'b0);
        wb(1'b1, ADR_CMD, 32'h1);
        st(1'b0);
        wb(1'b1, ADR_CMD, 32'h2);
        st(1'b1);
        wb(1'b1, ADR_TRSEL, 32'h0);
        wb(1'b1, ADR_PERSH, 32'h13);
        wb(1'b1, ADR_CMPSH, 32'h6);
        run(32'h0400_0003, 6'h31, 16'h9);
        wb(1'b1, ADR_CMD, 32'h8);
        repeat (60) @(posedge mclk);
        chk(hiPer, 20);
        chk(hiOn, 7);
        wb(1'b0, ADR_PER, 32'h13);
        wb(1'b0, ADR_PERSH, 32'h9);
        wb(1'b0, ADR_CMP, 32'h6);
        wb(1'b0, ADR_CMPSH, 32'h4);
        wb(1'b1, ADR_CTRL, 32'h0);
        repeat (3) @(posedge mclk);
        pw(2'h0);
        st(1'b0);
        give_verdict();
    end
endmodule : pkd_channel_tb
